// [rtl/bafc_pkg.sv]
// Purpose: Shared constants and types for the bus arbitration and fault control block
// Assumes: One 40 MHz clock; one bus-cycle state per clock
// Notes: Register offsets are byte addresses on the AHB-Lite slave

package bafc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ERRCNT_OFS = 8'h08;
  localparam int CTRL_TWO_WIRE_BIT = 0;
  localparam logic CTRL_TWO_WIRE_RST = 1'b0;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Bus cycle state numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] S_FIRST = 5'h00;
  localparam logic [4:0] S_AS_ON = 5'h02;
  localparam logic [4:0] S_RD_DS_ON = 5'h02;
  localparam logic [4:0] S_WR_RW_ON = 5'h02;
  localparam logic [4:0] S_WR_DATA_ON = 5'h03;
  localparam logic [4:0] S_WR_DS_ON = 5'h04;
  localparam logic [4:0] S_WAIT = 5'h04;
  localparam logic [4:0] S_RD_CAPTURE = 5'h06;
  localparam logic [4:0] S_END_OK = 5'h07;
  localparam logic [4:0] S_END_BE = 5'h09;
  localparam logic [4:0] S_RMW_RD_BE = 5'h0b;
  localparam logic [4:0] S_RMW_WR_START = 5'h0c;
  localparam logic [4:0] S_RMW_RW_ON = 5'h0e;
  localparam logic [4:0] S_RMW_DATA_ON = 5'h0f;
  localparam logic [4:0] S_RMW_WAIT = 5'h10;
  localparam logic [4:0] S_RMW_END_OK = 5'h13;
  localparam logic [4:0] S_RMW_WR_BE = 5'h15;

  // ----------------------------------------------------------------
  // Exception constants
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_BUS_ERR_ENTRY = 8'h02;
  localparam logic [7:0] VEC_BUS_ERR_OFS = 8'h08;
  localparam logic [3:0] STACK_SR_WORDS = 4'h1;
  localparam logic [3:0] STACK_PC_WORDS = 4'h2;
  localparam logic [3:0] STACK_ERR_WORDS = 4'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b000, ARB_DELAY = 3'b001, ARB_GRANT = 3'b010,
    ARB_ACKED = 3'b011, ARB_REGRANT = 3'b100
  } bafc_arb_e;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000, BUS_RUN = 3'b001, BUS_ERRWAIT = 3'b010,
    BUS_RETRY = 3'b011, BUS_DFAULT = 3'b100
  } bafc_bus_e;
  typedef enum logic [1:0] {
    K_READ = 2'b00, K_WRITE = 2'b01, K_RMW = 2'b10
  } bafc_kind_e;
  typedef enum logic [1:0] {
    END_OK = 2'b00, END_ERR = 2'b01, END_RETRY = 2'b10
  } bafc_end_e;

  typedef struct packed {
    logic valid;
    bafc_kind_e kind;
    logic is_byte;
    logic [2:0] fc;
    logic [31:0] addr;
    logic [15:0] wdata;
  } bafc_req_s;

  typedef struct packed {
    logic taken;
    logic done;
    logic err;
    logic [15:0] rdata;
    logic exc_req;
    logic [7:0] exc_vec_off;
    logic [3:0] exc_stack_words;
  } bafc_rsp_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] cycle_function_code;
    logic addr_oe;
    logic addr_strobe_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
    logic byte_strobe_n;
    logic rw_n;
    logic ctrl_oe;
    logic [15:0] data;
    logic data_oe;
  } bafc_pins_s;

endpackage

// [rtl/bafc_top.sv]
// Purpose: Bus arbitration, bus error, retry, halt and double fault control
// Assumes: Core presents one bus cycle request at a time; AHB-Lite register access
// Notes: bus_pins outputs are registered and trail the cycle state by one clock; grant and halt outputs are registered from the next state

`timescale 1ns/1ps

module bafc_top
  import bafc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic bus_request_in_n,
  input wire logic grant_ack_in_n,
  input wire logic xfer_ack_in_n,
  input wire logic bus_fault_in_n,
  input wire logic halt_request_in_n,
  input wire logic [15:0] data_in,
  output bafc_pins_s bus_pins,
  output logic bus_grant_out_n,
  output logic halted_out_n,
  input wire bafc_req_s core_req,
  input wire logic core_reset_fetch,
  input wire logic core_exc_end,
  output bafc_rsp_s core_rsp
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  wire [4:0] raw_w = {~bus_request_in_n, ~grant_ack_in_n, ~xfer_ack_in_n,
                      ~bus_fault_in_n, ~halt_request_in_n};

  // First stage on the falling edge, so inputs are valid after next rise
  always_ff @(negedge ref_clk) begin
    if (!rst_b) begin
      sync1_r <= 5'h00;
    end else if (clk_en) begin
      sync1_r <= raw_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync2_r <= 5'h00;
    end else if (clk_en) begin
      sync2_r <= sync1_r;
    end
  end

  logic two_wire_r;
  wire req_i = sync2_r[4];
  wire ack_i = sync2_r[3] & ~two_wire_r;
  wire dt_i = sync2_r[2];
  wire be_i = sync2_r[1];
  wire halt_i = sync2_r[0];

  // ----------------------------------------------------------------
  // Bus cycle state
  // ----------------------------------------------------------------
  bafc_arb_e arb_r;
  bafc_arb_e arb_nxt;
  bafc_bus_e bus_r;
  bafc_bus_e bus_nxt;
  bafc_end_e outc_r;
  bafc_req_s cyc_r;
  logic [4:0] st_r;
  logic [4:0] end_r;
  logic [4:0] rd_off_r;
  logic [4:0] wr_off_r;
  logic term_r;
  logic exc_active_r;
  logic [15:0] rdata_r;
  logic [15:0] err_cnt_r;
  logic [15:0] retry_cnt_r;
  logic tsc_r;
  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  wire wr_errcnt_w = ap_wr_r && (ap_addr_r == ERRCNT_OFS);

  wire is_rmw = (cyc_r.kind == K_RMW);
  wire is_wr = (cyc_r.kind == K_WRITE);
  wire wr_part = is_rmw && (st_r == S_RMW_WAIT);
  wire wait_pt = (bus_r == BUS_RUN) && !term_r &&
                 ((st_r == S_WAIT) || wr_part);
  wire dec_w = wait_pt && (be_i || dt_i);
  wire bus_err_w = dec_w && be_i && (!halt_i || is_rmw);
  wire retry_w = dec_w && be_i && halt_i && !is_rmw;
  wire at_end = (bus_r == BUS_RUN) && (st_r == end_r);

  // Only an idle arbiter lets a cycle start; halt blocks it
  wire arb_free = (arb_r == ARB_IDLE);
  wire new_start = (bus_r == BUS_IDLE) && core_req.valid;
  wire rerun = (bus_r == BUS_RETRY) && !be_i;
  wire cyc_start_w = arb_free && !halt_i && (new_start || rerun);
  wire fault_done = (bus_r == BUS_ERRWAIT) && !be_i;
  wire dbl_fault_w = fault_done && (exc_active_r || core_reset_fetch);
  wire exc_go_w = fault_done && !dbl_fault_w;

  // Termination point chosen at the wait state
  wire [4:0] plain_end = dt_i ? S_END_OK : S_END_BE;
  wire [4:0] rmw_end = wr_part ? (dt_i ? S_RMW_END_OK : S_RMW_WR_BE) : S_RMW_RD_BE;
  wire [4:0] be_end = is_rmw ? rmw_end : plain_end;

  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      BUS_IDLE: begin
        if (cyc_start_w) begin
          bus_nxt = BUS_RUN;
        end
      end
      BUS_RUN: begin
        if (at_end) begin
          if (outc_r == END_OK) begin
            bus_nxt = BUS_IDLE;
          end else if (outc_r == END_RETRY) begin
            bus_nxt = BUS_RETRY;
          end else begin
            bus_nxt = BUS_ERRWAIT;
          end
        end
      end
      BUS_ERRWAIT: begin
        if (dbl_fault_w) begin
          bus_nxt = BUS_DFAULT;
        end else if (exc_go_w) begin
          bus_nxt = BUS_IDLE;
        end
      end
      BUS_RETRY: begin
        if (cyc_start_w) begin
          bus_nxt = BUS_RUN;
        end
      end
      BUS_DFAULT: bus_nxt = BUS_DFAULT;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus_r <= BUS_IDLE;
      st_r <= S_FIRST;
      end_r <= S_END_OK;
      rd_off_r <= S_END_OK;
      wr_off_r <= S_END_OK;
      term_r <= 1'b0;
      outc_r <= END_OK;
      cyc_r <= '0;
    end else if (clk_en) begin
      bus_r <= bus_nxt;
      if (cyc_start_w) begin
        // A retry keeps the latched request untouched
        if (new_start) begin
          cyc_r <= core_req;
        end
        st_r <= S_FIRST;
        term_r <= 1'b0;
        outc_r <= END_OK;
        end_r <= ((new_start ? core_req.kind : cyc_r.kind) == K_RMW) ? S_RMW_END_OK : S_END_OK;
        rd_off_r <= S_END_OK;
        wr_off_r <= ((new_start ? core_req.kind : cyc_r.kind) == K_RMW) ? S_RMW_END_OK : S_END_OK;
      end else if (dec_w) begin
        st_r <= st_r + 5'h01;
        if (be_i) begin
          term_r <= 1'b1;
          end_r <= be_end;
          outc_r <= retry_w ? END_RETRY : END_ERR;
          if (is_rmw && !wr_part) begin
            rd_off_r <= plain_end;
          end else if (is_wr || wr_part) begin
            wr_off_r <= be_end;
          end else begin
            rd_off_r <= plain_end;
          end
        end else if (!(is_rmw && !wr_part)) begin
          term_r <= 1'b1;
        end
      end else if ((bus_r == BUS_RUN) && !at_end && !wait_pt) begin
        st_r <= st_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception, read data and counters
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      exc_active_r <= 1'b0;
      rdata_r <= 16'h0000;
      err_cnt_r <= CNT_RST;
      retry_cnt_r <= CNT_RST;
    end else if (clk_en) begin
      if (exc_go_w) begin
        exc_active_r <= 1'b1;
      end else if (core_exc_end) begin
        exc_active_r <= 1'b0;
      end
      if ((bus_r == BUS_RUN) && !is_wr && (st_r == S_RD_CAPTURE)) begin
        rdata_r <= data_in;
      end
      // A clearing write in the same cycle as a count restarts the counter at one
      if (bus_err_w) begin
        err_cnt_r <= wr_errcnt_w ? 16'h0001 : err_cnt_r + 16'h0001;
      end else if (wr_errcnt_w) begin
        err_cnt_r <= CNT_RST;
      end
      if (retry_w) begin
        retry_cnt_r <= wr_errcnt_w ? 16'h0001 : retry_cnt_r + 16'h0001;
      end else if (wr_errcnt_w) begin
        retry_cnt_r <= CNT_RST;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      core_rsp <= '0;
    end else if (clk_en) begin
      core_rsp.taken <= cyc_start_w && new_start;
      core_rsp.done <= (at_end && (outc_r == END_OK)) || exc_go_w;
      core_rsp.err <= exc_go_w;
      core_rsp.rdata <= rdata_r;
      core_rsp.exc_req <= exc_go_w;
      core_rsp.exc_vec_off <= VEC_BUS_ERR_OFS;
      core_rsp.exc_stack_words <= STACK_SR_WORDS + STACK_PC_WORDS + STACK_ERR_WORDS;
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  always_comb begin
    arb_nxt = arb_r;
    case (arb_r)
      ARB_IDLE: begin
        if (req_i) begin
          arb_nxt = (cyc_start_w && new_start) ? ARB_DELAY : ARB_GRANT;
        end
      end
      ARB_DELAY: arb_nxt = req_i ? ARB_GRANT : ARB_IDLE;
      ARB_GRANT: begin
        if (ack_i) begin
          arb_nxt = ARB_ACKED;
        end else if (!req_i) begin
          arb_nxt = ARB_IDLE;
        end
      end
      ARB_ACKED: begin
        if (!ack_i) begin
          arb_nxt = req_i ? ARB_GRANT : ARB_IDLE;
        end else if (req_i) begin
          arb_nxt = ARB_REGRANT;
        end
      end
      ARB_REGRANT: begin
        if (!ack_i) begin
          arb_nxt = ARB_GRANT;
        end else if (!req_i) begin
          arb_nxt = ARB_ACKED;
        end
      end
      default: arb_nxt = ARB_IDLE;
    endcase
  end

  wire grant_nxt = (arb_nxt == ARB_GRANT) || (arb_nxt == ARB_REGRANT);
  wire tsc_nxt = grant_nxt || (arb_nxt == ARB_ACKED);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      arb_r <= ARB_IDLE;
      bus_grant_out_n <= 1'b1;
      tsc_r <= 1'b0;
      halted_out_n <= 1'b1;
    end else if (clk_en) begin
      arb_r <= arb_nxt;
      bus_grant_out_n <= ~grant_nxt;
      tsc_r <= tsc_nxt;
      halted_out_n <= ~(dbl_fault_w || (bus_r == BUS_DFAULT));
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire running = (bus_r == BUS_RUN);
  wire as_act = running && (st_r >= S_AS_ON) && (st_r <= end_r);
  wire ds_rd = !is_wr && (st_r >= S_RD_DS_ON) && (st_r < rd_off_r) && (st_r < S_RMW_WR_START);
  wire ds_wr = (is_wr && (st_r >= S_WR_DS_ON) && (st_r < wr_off_r)) ||
               (is_rmw && (st_r >= S_RMW_WAIT) && (st_r < wr_off_r));
  wire ds_act = running && (ds_rd || ds_wr);
  wire rw_low = running && (st_r <= end_r) &&
                ((is_wr && (st_r >= S_WR_RW_ON)) || (is_rmw && (st_r >= S_RMW_RW_ON)));
  wire data_drv = running && (st_r <= end_r) &&
                  ((is_wr && (st_r >= S_WR_DATA_ON)) || (is_rmw && (st_r >= S_RMW_DATA_ON)));
  wire bus_float = tsc_r && !as_act;
  wire upper_sel = !cyc_r.is_byte || !cyc_r.addr[0];
  wire lower_sel = !cyc_r.is_byte || cyc_r.addr[0];

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus_pins <= '0;
      bus_pins.addr_strobe_n <= 1'b1;
      bus_pins.upper_byte_strobe_n <= 1'b1;
      bus_pins.lower_byte_strobe_n <= 1'b1;
      bus_pins.byte_strobe_n <= 1'b1;
      bus_pins.rw_n <= 1'b1;
    end else if (clk_en) begin
      bus_pins.addr <= cyc_r.addr;
      bus_pins.cycle_function_code <= cyc_r.fc;
      bus_pins.data <= cyc_r.wdata;
      bus_pins.addr_strobe_n <= ~as_act;
      bus_pins.upper_byte_strobe_n <= ~(ds_act && upper_sel);
      bus_pins.lower_byte_strobe_n <= ~(ds_act && lower_sel);
      bus_pins.byte_strobe_n <= ~ds_act;
      bus_pins.rw_n <= ~rw_low;
      bus_pins.addr_oe <= !bus_float;
      bus_pins.ctrl_oe <= !bus_float;
      // Data only driven inside a write cycle, and a bus fault leaves it floating
      bus_pins.data_oe <= data_drv && !be_i && !bus_float;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  wire ap_take = hsel && htrans[1] && hready;
  wire mapped = (haddr[31:8] == 24'h000000);
  wire wr_ctrl_w = ap_wr_r && (ap_addr_r == CTRL_OFS);
  wire [31:0] stat_w = {14'h0000, (bus_r == BUS_DFAULT), exc_active_r, halt_i, bus_r,
                        arb_r, st_r, ~bus_grant_out_n, tsc_r, 2'b00};
  wire [31:0] rd_mux = !mapped ? 32'h00000000 :
                       (haddr[7:0] == CTRL_OFS) ? {31'h00000000, two_wire_r} :
                       (haddr[7:0] == STAT_OFS) ? stat_w :
                       (haddr[7:0] == ERRCNT_OFS) ? {retry_cnt_r, err_cnt_r} : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      two_wire_r <= CTRL_TWO_WIRE_RST;
    end else if (clk_en) begin
      ap_wr_r <= ap_take && hwrite && mapped;
      ap_addr_r <= haddr[7:0];
      hrdata <= (ap_take && !hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (wr_ctrl_w) begin
        two_wire_r <= hwdata[CTRL_TWO_WIRE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b || !clk_en);

  a_grant_on_req:
    assert property (arb_r == ARB_IDLE && req_i && !cyc_start_w |=> !bus_grant_out_n)
    else $error("grant not given one edge after request");
  a_special_delay:
    assert property (arb_r == ARB_IDLE && req_i && cyc_start_w && new_start
                     |=> bus_grant_out_n ##1 (!bus_grant_out_n || !$past(req_i)))
    else $error("special case grant timing wrong");
  a_two_wire_states:
    assert property (two_wire_r && $past(two_wire_r)
                     |-> arb_r inside {ARB_IDLE, ARB_DELAY, ARB_GRANT})
    else $error("two-wire arbiter left its three states");
  a_float_tsc:
    assert property (tsc_r && !as_act |=> !bus_pins.addr_oe && !bus_pins.ctrl_oe
                     && !bus_pins.data_oe)
    else $error("bus driven while three-state control set");
  a_fault_data_off:
    assert property (be_i |=> !bus_pins.data_oe)
    else $error("data bus driven during fault");
  a_plain_err_end:
    assert property (dec_w && be_i && !halt_i && !is_rmw
                     |=> end_r == ($past(dt_i) ? S_END_OK : S_END_BE))
    else $error("plain cycle error end state wrong");
  a_rmw_no_retry:
    assert property (dec_w && be_i && is_rmw |=> outc_r == END_ERR)
    else $error("locked cycle was retried");
  a_grant_drop:
    assert property (arb_r == ARB_GRANT && ack_i |=> bus_grant_out_n)
    else $error("grant held after acknowledge");
  a_withdraw_req:
    assert property (arb_r == ARB_GRANT && !req_i && !ack_i
                     |=> bus_grant_out_n && arb_r == ARB_IDLE)
    else $error("grant kept after request withdrawn");
  a_halt_blocks:
    assert property (halt_i && bus_r == BUS_IDLE |=> bus_r != BUS_RUN)
    else $error("cycle started under halt");
  a_double_fault:
    assert property (bus_r == BUS_ERRWAIT && !be_i && exc_active_r
                     |=> bus_r == BUS_DFAULT ##1 !halted_out_n)
    else $error("double fault not taken");
  a_dfault_sticky:
    assert property (!halted_out_n |=> !halted_out_n)
    else $error("double fault halt released without reset");
  a_retry_no_exc:
    assert property (bus_r == BUS_RETRY |=> !core_rsp.exc_req)
    else $error("retry raised an exception");

  c_retry: cover property (bus_r == BUS_RETRY ##[1:50] bus_r == BUS_RUN);
  c_double_fault: cover property (bus_r == BUS_DFAULT);
  c_regrant: cover property (arb_r == ARB_REGRANT);
  c_special: cover property (arb_r == ARB_DELAY ##1 arb_r == ARB_GRANT);

endmodule

// [verification/bafc_far_model.sv]
// Purpose: Far-side slave, bus-timeout and halt logic model
// Assumes: Answers three clocks after the data strobe falls
// Notes: mode 0 ack, 1 fault, 2 fault with ack, 3 fault with halt (once)
`timescale 1ns/1ps
module bafc_far_model
  import bafc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire bafc_pins_s bus_pins,
  input wire logic [1:0] mode,
  input wire logic hold_halt,
  input wire logic [15:0] rd_val,
  output logic xfer_ack_in_n,
  output logic bus_fault_in_n,
  output logic halt_request_in_n,
  output logic [15:0] data_in
);
  logic [1:0] cnt_r;
  logic [1:0] eff_mode;
  logic halt_r;
  logic retried_r;
  // Rerun after a retry is acknowledged, else it would loop for ever
  assign eff_mode = (mode == 2'h3 && retried_r) ? 2'h0 : mode;
  // Released data lines show the inverse so a stale value never matches
  assign data_in = bus_pins.byte_strobe_n ? ~rd_val : rd_val;
  assign halt_request_in_n = ~(hold_halt | halt_r);
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_r <= 2'h0;
      xfer_ack_in_n <= 1'b1;
      bus_fault_in_n <= 1'b1;
      halt_r <= 1'b0;
      retried_r <= 1'b0;
    end else if (bus_pins.addr_strobe_n) begin
      cnt_r <= 2'h0;
      xfer_ack_in_n <= 1'b1;
      bus_fault_in_n <= 1'b1;
      halt_r <= halt_r & ~bus_fault_in_n;
      retried_r <= retried_r & (mode == 2'h3);
    end else if (bus_pins.byte_strobe_n) begin
      cnt_r <= 2'h0;
      xfer_ack_in_n <= 1'b1;
    end else if (cnt_r != 2'h2) begin
      cnt_r <= cnt_r + 2'h1;
    end else if (xfer_ack_in_n && bus_fault_in_n) begin
      xfer_ack_in_n <= eff_mode[0];
      bus_fault_in_n <= (eff_mode == 2'h0);
      halt_r <= (eff_mode == 2'h3);
      retried_r <= retried_r | (eff_mode == 2'h3);
    end
  end
endmodule

// [verification/bus_arbitration_fault_control_test.sv]
// Purpose: Self-checking bench for bus arbitration and fault control
// Assumes: Zero-wait register slave; far side from bafc_far_model
// Notes: Expected cycle outcomes queue up and are matched on done
`timescale 1ns/1ps
module bus_arbitration_fault_control_test
  import bafc_pkg::*;
;
  logic ref_clk = 0, rst_b = 0, clk_en = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0, mode = 0;
  logic [2:0] hsize = 3'h2;
  logic bus_request_in_n = 1, grant_ack_in_n = 1, xfer_ack_in_n, bus_fault_in_n;
  logic halt_request_in_n, bus_grant_out_n, halted_out_n;
  logic core_reset_fetch = 0, core_exc_end = 0, hold_halt = 0, keep_exc = 0;
  logic [15:0] data_in, rd_val = 0, lfsr = 16'h0063;
  logic [17:0] ent;
  bafc_pins_s bus_pins;
  bafc_req_s core_req = '0;
  bafc_rsp_s core_rsp;
  logic [17:0] exp_q[$];
  int mismatches = 0, total_checks = 0, n;
  assign hready = hreadyout;
  bafc_top dut_u (
    .ref_clk, .rst_b, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .bus_request_in_n, .grant_ack_in_n,
    .xfer_ack_in_n, .bus_fault_in_n, .halt_request_in_n, .data_in, .bus_pins,
    .bus_grant_out_n, .halted_out_n, .core_req, .core_reset_fetch, .core_exc_end,
    .core_rsp
  );
  bafc_far_model far_u (
    .ref_clk, .rst_b, .bus_pins, .mode, .hold_halt, .rd_val, .xfer_ack_in_n,
    .bus_fault_in_n, .halt_request_in_n, .data_in
  );
  initial forever #12.5 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task rst;
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 0, hresp);
  endtask
  // Outcome e: 0 completes, 1 bus error, 2 double fault
  task issue(input bafc_kind_e k, input logic [1:0] m, input logic [1:0] e);
    mode <= m;
    rd_val <= lfsr;
    if (e != 2'h2) exp_q.push_back({e[0], k == K_READ, lfsr});
    core_req <= '{1'b1, k, 1'b0, 3'h5, {15'h0, lfsr, 1'b0}, ~lfsr};
    lfsr = nxt(lfsr);
    n = 0;
    do @(posedge ref_clk); while (core_rsp.taken !== 1'b1 && ++n < 100);
    core_req.valid <= 1'b0;
    do @(posedge ref_clk); while (core_rsp.done !== 1'b1 && halted_out_n !== 1'b0);
    core_exc_end <= (e == 2'h1) & ~keep_exc;
    @(posedge ref_clk);
    core_exc_end <= 1'b0;
  endtask
  // Request, optionally acknowledge, then withdraw
  task arb(input logic ack);
    bus_request_in_n <= 1'b0;
    n = 0;
    do @(posedge ref_clk); while (bus_grant_out_n !== 1'b0 && ++n < 20);
    chk("grant delay", 1, n >= 2 && n <= 3);
    grant_ack_in_n <= ~ack;
    bus_request_in_n <= 1'b1;
    n = 0;
    do @(posedge ref_clk); while (bus_grant_out_n !== 1'b1 && ++n < 20);
    chk("grant drop", 1, n >= 1 && n <= 3);
    if (ack) chk("float", 0, {bus_pins.addr_oe, bus_pins.ctrl_oe, bus_pins.data_oe});
    grant_ack_in_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // Result watcher and main sequence
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (core_rsp.done === 1'b1) begin
      chk("done count", 1, exp_q.size() > 0);
      ent = exp_q.pop_front();
      chk("err", ent[17], core_rsp.err);
      chk("exc", ent[17], core_rsp.exc_req);
      if (ent[16] && !ent[17]) chk("rdata", ent[15:0], core_rsp.rdata);
      chk("addr", {15'h0, ent[15:0], 1'b0}, bus_pins.addr);
      chk("fc", 32'h5, bus_pins.cycle_function_code);
      if (!ent[16]) chk("wdata", {16'h0, ~ent[15:0]}, bus_pins.data);
      if (ent[17]) chk("vec", 12'h087, {core_rsp.exc_vec_off, core_rsp.exc_stack_words});
    end
  end
  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run;
  end
  initial begin
    rst;
    ahb(1'b0, 32'(CTRL_OFS), 0);
    chk("ctrl", 0, q);
    ahb(1'b1, 32'h0000000c, 32'hffffffff);
    ahb(1'b0, 32'h0000000c, 0);
    chk("unmapped", 0, q);
    issue(K_READ, 2'h0, 2'h0);
    issue(K_WRITE, 2'h0, 2'h0);
    issue(K_READ, 2'h1, 2'h1);
    issue(K_WRITE, 2'h2, 2'h1);
    issue(K_READ, 2'h3, 2'h0);
    issue(K_RMW, 2'h0, 2'h0);
    issue(K_RMW, 2'h3, 2'h1);
    ahb(1'b0, 32'(ERRCNT_OFS), 0);
    chk("errcnt", 32'h00010003, q);
    arb(1'b1);
    arb(1'b0);
    // Enable low must freeze the arbiter, request included
    clk_en <= 1'b0;
    bus_request_in_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("frozen", 1, bus_grant_out_n);
    clk_en <= 1'b1;
    bus_request_in_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ahb(1'b1, 32'(CTRL_OFS), 1);
    ahb(1'b0, 32'(CTRL_OFS), 0);
    chk("ctrl", 1, q);
    arb(1'b0);
    ahb(1'b1, 32'(CTRL_OFS), 0);
    hold_halt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    arb(1'b1);
    fork
      begin
        repeat (10) @(posedge ref_clk);
        hold_halt <= 1'b0;
      end
    join_none
    issue(K_READ, 2'h0, 2'h0);
    chk("halt stall", 1, n > 7);
    keep_exc <= 1'b1;
    issue(K_READ, 2'h1, 2'h1);
    issue(K_READ, 2'h1, 2'h2);
    repeat (20) @(posedge ref_clk);
    chk("dfault", 0, halted_out_n);
    rst;
    chk("restart", 1, halted_out_n);
    keep_exc <= 1'b0;
    core_reset_fetch <= 1'b1;
    issue(K_READ, 2'h1, 2'h2);
    chk("reset fetch", 0, halted_out_n);
    core_reset_fetch <= 1'b0;
    rst;
    chk("pending", 0, exp_q.size());
    complete_run;
  end
endmodule
